// ===== design/iec_pkg.sv
package iec_pkg;

  localparam int          IEC_AW              = 8;
  localparam int          IEC_DW              = 32;

  localparam logic [7:0]  IEC_OFS_CONTROL     = 8'h00;
  localparam logic [7:0]  IEC_OFS_PENABLE1    = 8'h04;
  localparam logic [7:0]  IEC_OFS_PENABLE2    = 8'h08;
  localparam logic [7:0]  IEC_OFS_PENABLE3    = 8'h0C;
  localparam logic [7:0]  IEC_OFS_PREQUEST1   = 8'h10;
  localparam logic [7:0]  IEC_OFS_PREQUEST2   = 8'h14;
  localparam logic [7:0]  IEC_OFS_PREQUEST3   = 8'h18;
  localparam logic [7:0]  IEC_OFS_OPTION      = 8'h1C;
  localparam logic [7:0]  IEC_OFS_SH_W        = 8'h40;
  localparam logic [7:0]  IEC_OFS_SH_STATUS   = 8'h44;
  localparam logic [7:0]  IEC_OFS_SH_BSR      = 8'h48;
  localparam logic [7:0]  IEC_OFS_SH_FSR0     = 8'h4C;
  localparam logic [7:0]  IEC_OFS_SH_FSR1     = 8'h50;
  localparam logic [7:0]  IEC_OFS_SH_PC_HIGH_LATCH   = 8'h54;

  localparam int          IEC_BIT_GIE         = 7;
  localparam int          IEC_BIT_PERIPHERAL_GROUP_ENABLE        = 6;
  localparam int          IEC_BIT_TMR0_EN     = 5;
  localparam int          IEC_BIT_EXT_EN      = 4;
  localparam int          IEC_BIT_CHG_EN      = 3;
  localparam int          IEC_BIT_TMR0_FLAG   = 2;
  localparam int          IEC_BIT_EXT_FLAG    = 1;
  localparam int          IEC_BIT_CHG_SUMMARY = 0;
  localparam int          IEC_BIT_EDGE_SEL    = 0;
  localparam int          IEC_BIT_TIMEOUT     = 4;
  localparam int          IEC_BIT_POWERDOWN   = 3;

  localparam logic [7:0]  IEC_PE1_MASK        = 8'hF3;
  localparam logic [7:0]  IEC_PE2_MASK        = 8'h20;
  localparam logic [7:0]  IEC_PE3_MASK        = 8'h70;
  localparam logic [7:0]  IEC_PR1_WMASK       = 8'hF3;
  localparam logic [7:0]  IEC_PR2_WMASK       = 8'h20;
  localparam logic [7:0]  IEC_PR3_WMASK       = 8'h00;
  localparam logic [7:0]  IEC_STATUS_SAVE     = 8'hE7;

  localparam logic [7:0]  IEC_RST_BYTE        = 8'h00;
  localparam logic [15:0] IEC_RST_WORD        = 16'h0000;
  localparam logic [15:0] IEC_VECTOR_ADDR     = 16'h0004;

  localparam int          IEC_PHASES          = 4;
  localparam logic [1:0]  IEC_PH_ONE          = 2'h0;
  localparam logic [1:0]  IEC_PH_FOUR         = 2'h3;
  localparam logic [1:0]  IEC_WAKE_CYCLES     = 2'h3;

  typedef enum logic [1:0] {
    IEC_ST_RUN   = 2'b00,
    IEC_ST_SLEEP = 2'b01,
    IEC_ST_WAKE  = 2'b10
  } iec_state_t;

endpackage

// ===== design/iec_sync2.sv
`timescale 1ns/100ps
module iec_sync2 (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta_r;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_r <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule

// ===== design/iec_flag_reg.sv
`timescale 1ns/100ps
module iec_flag_reg #(
  parameter int         W     = 8,
  parameter logic [7:0] WMASK = 8'hFF
) (
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] set_i,
  input  wire logic         wr_i,
  input  wire logic [W-1:0] wdata_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] mask;
  logic [W-1:0] q_nxt;

  assign mask = WMASK[W-1:0];

  // A hardware set in the same cycle as a software write wins, so no event is lost.
  always_comb begin
    q_nxt = q_o;
    if (wr_i) begin
      q_nxt = (q_o & ~mask) | (wdata_i & mask);
    end
    q_nxt = q_nxt | set_i;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      q_o <= '0;
    end else begin
      q_o <= q_nxt;
    end
  end
endmodule

// ===== design/iec_top.sv
`timescale 1ns/100ps
module iec_top (
  input  wire logic                     clk_i,
  input  wire logic                     reset_i,
  input  wire logic [iec_pkg::IEC_AW-1:0] avs_address_i,
  input  wire logic                     avs_read_i,
  input  wire logic                     avs_write_i,
  input  wire logic [3:0]               avs_byteenable_i,
  input  wire logic [iec_pkg::IEC_DW-1:0] avs_writedata_i,
  output logic      [iec_pkg::IEC_DW-1:0] avs_readdata_o,
  output logic                          avs_waitrequest_o,
  input  wire logic                     tmr0_evt_i,
  input  wire logic [7:0]               periph_evt1_i,
  input  wire logic [7:0]               periph_evt2_i,
  input  wire logic [7:0]               periph_evt3_i,
  input  wire logic [5:0]               change_flags_i,
  input  wire logic                     ext_pin_i,
  input  wire logic                     sleep_i,
  input  wire logic                     return_from_interrupt_instr_i,
  input  wire logic [15:0]              pc_i,
  input  wire logic [7:0]               ctx_w_i,
  input  wire logic [7:0]               ctx_status_i,
  input  wire logic [4:0]               ctx_bsr_i,
  input  wire logic [15:0]              ctx_fsr0_i,
  input  wire logic [15:0]              ctx_fsr1_i,
  input  wire logic [6:0]               ctx_pc_high_latch_i,
  output logic      [1:0]               phase_o,
  output logic                          vector_take_o,
  output logic      [15:0]              vector_pc_o,
  output logic      [15:0]              push_pc_o,
  output logic                          restore_o,
  output logic                          wake_o,
  output logic                          global_irq_enable_o,
  output logic      [7:0]               sh_w_o,
  output logic      [7:0]               sh_status_o,
  output logic      [4:0]               sh_bsr_o,
  output logic      [15:0]              sh_fsr0_o,
  output logic      [15:0]              sh_fsr1_o,
  output logic      [6:0]               sh_pc_high_latch_o
);
  import iec_pkg::*;

  logic        ack_r, wr_go, gie_r, peripheral_group_enable_r, tmr0_en_r, ext_en_r, chg_en_r, edge_sel_r;
  logic        chg_summary, ext_sync, ext_prev_r, ext_edge, periph_req, irq_any, take_nxt;
  logic [7:0]  wb, pe1_r, pe2_r, pe3_r, pr1, pr2, pr3;
  logic [1:0]  core_flags, phase_r, wake_cnt_r;
  iec_state_t  state_r;
  logic [31:0] rd_nxt;

  assign wb          = avs_writedata_i[7:0];
  assign wr_go       = avs_write_i && ack_r && avs_byteenable_i[0];
  assign chg_summary = |change_flags_i;
  assign phase_o     = phase_r;
  assign global_irq_enable_o = gie_r;
  // One wait state per access; the data register is loaded while waitrequest is high.
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_r;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read_i || avs_write_i) && !ack_r;
    end
  end

  always_comb begin
    rd_nxt = '0;
    case (avs_address_i)
      IEC_OFS_CONTROL:   rd_nxt[7:0] = {gie_r, peripheral_group_enable_r, tmr0_en_r, ext_en_r, chg_en_r, core_flags, chg_summary};
      IEC_OFS_PENABLE1:  rd_nxt[7:0] = pe1_r;
      IEC_OFS_PENABLE2:  rd_nxt[7:0] = pe2_r;
      IEC_OFS_PENABLE3:  rd_nxt[7:0] = pe3_r;
      IEC_OFS_PREQUEST1: rd_nxt[7:0] = pr1;
      IEC_OFS_PREQUEST2: rd_nxt[7:0] = pr2;
      IEC_OFS_PREQUEST3: rd_nxt[7:0] = pr3;
      IEC_OFS_OPTION:    rd_nxt[0]   = edge_sel_r;
      IEC_OFS_SH_W:      rd_nxt[7:0] = sh_w_o;
      IEC_OFS_SH_STATUS: rd_nxt[7:0] = sh_status_o;
      IEC_OFS_SH_BSR:    rd_nxt[4:0] = sh_bsr_o;
      IEC_OFS_SH_FSR0:   rd_nxt[15:0] = sh_fsr0_o;
      IEC_OFS_SH_FSR1:   rd_nxt[15:0] = sh_fsr1_o;
      IEC_OFS_SH_PC_HIGH_LATCH: rd_nxt[6:0] = sh_pc_high_latch_o;
      default:           rd_nxt = '0;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      avs_readdata_o <= '0;
    end else if (avs_read_i && !ack_r) begin
      avs_readdata_o <= rd_nxt;
    end
  end

  // Enables clear on every reset, so nothing can vector until firmware asks for it.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      peripheral_group_enable_r     <= 1'b0;
      tmr0_en_r  <= 1'b0;
      ext_en_r   <= 1'b0;
      chg_en_r   <= 1'b0;
      edge_sel_r <= 1'b0;
      pe1_r      <= IEC_RST_BYTE;
      pe2_r      <= IEC_RST_BYTE;
      pe3_r      <= IEC_RST_BYTE;
    end else if (wr_go) begin
      case (avs_address_i)
        IEC_OFS_CONTROL: begin
          peripheral_group_enable_r    <= wb[IEC_BIT_PERIPHERAL_GROUP_ENABLE];
          tmr0_en_r <= wb[IEC_BIT_TMR0_EN];
          ext_en_r  <= wb[IEC_BIT_EXT_EN];
          chg_en_r  <= wb[IEC_BIT_CHG_EN];
        end
        IEC_OFS_PENABLE1: pe1_r <= wb & IEC_PE1_MASK;
        IEC_OFS_PENABLE2: pe2_r <= wb & IEC_PE2_MASK;
        IEC_OFS_PENABLE3: pe3_r <= wb & IEC_PE3_MASK;
        IEC_OFS_OPTION:   edge_sel_r <= wb[IEC_BIT_EDGE_SEL];
        default: ;
      endcase
    end
  end

  // Entry clear has priority over the return and over a software write.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      gie_r <= 1'b0;
    end else if (take_nxt) begin
      gie_r <= 1'b0;
    end else if (return_from_interrupt_instr_i) begin
      gie_r <= 1'b1;
    end else if (wr_go && avs_address_i == IEC_OFS_CONTROL) begin
      gie_r <= wb[IEC_BIT_GIE];
    end
  end

  iec_sync2 u_ext_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .async_i (ext_pin_i),
    .sync_o  (ext_sync)
  );
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ext_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= ext_sync;
    end
  end

  assign ext_edge = edge_sel_r ? (ext_sync && !ext_prev_r) : (!ext_sync && ext_prev_r);

  // Flags set with no regard to any enable bit.
  iec_flag_reg #(.W(2), .WMASK(8'h03)) u_core_flags (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .set_i   ({tmr0_evt_i, ext_edge}),
    .wr_i    (wr_go && avs_address_i == IEC_OFS_CONTROL),
    .wdata_i (wb[IEC_BIT_TMR0_FLAG:IEC_BIT_EXT_FLAG]),
    .q_o     (core_flags)
  );
  iec_flag_reg #(.W(8), .WMASK(IEC_PR1_WMASK)) u_pr1 (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .set_i   (periph_evt1_i & IEC_PE1_MASK),
    .wr_i    (wr_go && avs_address_i == IEC_OFS_PREQUEST1),
    .wdata_i (wb),
    .q_o     (pr1)
  );
  iec_flag_reg #(.W(8), .WMASK(IEC_PR2_WMASK)) u_pr2 (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .set_i   (periph_evt2_i & IEC_PE2_MASK),
    .wr_i    (wr_go && avs_address_i == IEC_OFS_PREQUEST2),
    .wdata_i (wb),
    .q_o     (pr2)
  );
  // These flags are cleared by reset only, so software writes are masked out.
  iec_flag_reg #(.W(8), .WMASK(IEC_PR3_WMASK)) u_pr3 (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .set_i   (periph_evt3_i & IEC_PE3_MASK),
    .wr_i    (wr_go && avs_address_i == IEC_OFS_PREQUEST3),
    .wdata_i (wb),
    .q_o     (pr3)
  );
  assign periph_req = |(pr1 & pe1_r) || |(pr2 & pe2_r) || |(pr3 & pe3_r);
  assign irq_any = (tmr0_en_r && core_flags[1]) || (ext_en_r && core_flags[0]) ||
                   (chg_en_r && chg_summary) || (peripheral_group_enable_r && periph_req);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      phase_r <= IEC_PH_ONE;
    end else begin
      phase_r <= (phase_r == IEC_PH_FOUR) ? IEC_PH_ONE : phase_r + 2'h1;
    end
  end
  // Requests are looked at only in phase one, whatever the instruction length.
  assign take_nxt = (state_r == IEC_ST_RUN) && (phase_r == IEC_PH_ONE) && gie_r && irq_any;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r    <= IEC_ST_RUN;
      wake_cnt_r <= 2'h0;
      wake_o     <= 1'b0;
    end else begin
      wake_o <= 1'b0;
      case (state_r)
        IEC_ST_RUN: if (sleep_i && !take_nxt) state_r <= IEC_ST_SLEEP;
        IEC_ST_SLEEP: begin
          // Wake ignores the global enable; it only decides whether a vector follows.
          if (irq_any) begin
            wake_o     <= 1'b1;
            wake_cnt_r <= 2'h0;
            state_r    <= IEC_ST_WAKE;
          end
        end
        IEC_ST_WAKE: begin
          wake_cnt_r <= wake_cnt_r + 2'h1;
          if (wake_cnt_r == IEC_WAKE_CYCLES) state_r <= IEC_ST_RUN;
        end
        default: state_r <= IEC_ST_RUN;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      vector_take_o <= 1'b0;
      vector_pc_o   <= IEC_RST_WORD;
      push_pc_o     <= IEC_RST_WORD;
      restore_o     <= 1'b0;
    end else begin
      vector_take_o <= take_nxt;
      restore_o     <= return_from_interrupt_instr_i && !take_nxt;
      if (take_nxt) begin
        vector_pc_o <= IEC_VECTOR_ADDR;
        push_pc_o   <= pc_i;
      end
    end
  end

  // Hardware save wins over a software write to the same shadow copy.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sh_w_o      <= IEC_RST_BYTE;
      sh_status_o <= IEC_RST_BYTE;
      sh_bsr_o    <= IEC_RST_BYTE[4:0];
      sh_fsr0_o   <= IEC_RST_WORD;
      sh_fsr1_o   <= IEC_RST_WORD;
      sh_pc_high_latch_o <= IEC_RST_BYTE[6:0];
    end else if (take_nxt) begin
      sh_w_o      <= ctx_w_i;
      sh_status_o <= ctx_status_i & IEC_STATUS_SAVE;
      sh_bsr_o    <= ctx_bsr_i;
      sh_fsr0_o   <= ctx_fsr0_i;
      sh_fsr1_o   <= ctx_fsr1_i;
      sh_pc_high_latch_o <= ctx_pc_high_latch_i;
    end else if (avs_write_i && ack_r) begin
      case (avs_address_i)
        IEC_OFS_SH_W:      if (avs_byteenable_i[0]) sh_w_o <= wb;
        IEC_OFS_SH_STATUS: if (avs_byteenable_i[0]) sh_status_o <= wb & IEC_STATUS_SAVE;
        IEC_OFS_SH_BSR:    if (avs_byteenable_i[0]) sh_bsr_o <= wb[4:0];
        IEC_OFS_SH_FSR0: begin
          if (avs_byteenable_i[0]) sh_fsr0_o[7:0] <= wb;
          if (avs_byteenable_i[1]) sh_fsr0_o[15:8] <= avs_writedata_i[15:8];
        end
        IEC_OFS_SH_FSR1: begin
          if (avs_byteenable_i[0]) sh_fsr1_o[7:0] <= wb;
          if (avs_byteenable_i[1]) sh_fsr1_o[15:8] <= avs_writedata_i[15:8];
        end
        IEC_OFS_SH_PC_HIGH_LATCH: if (avs_byteenable_i[0]) sh_pc_high_latch_o <= wb[6:0];
        default: ;
      endcase
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_reset_gie_off: assert property ($past(reset_i) |-> !gie_r)
    else $error("global enable set straight after reset");
  a_take_needs_enables: assert property (vector_take_o |-> $past(gie_r) && $past(irq_any))
    else $error("vector taken without enables");
  a_take_clears_gie: assert property (vector_take_o |-> !gie_r && vector_pc_o == IEC_VECTOR_ADDR)
    else $error("entry did not clear enable or load vector");
  a_flag_no_enable: assert property (tmr0_evt_i |=> core_flags[1])
    else $error("timer flag not set by event");
  a_pending_taken: assert property (take_nxt |=> vector_take_o ##1 !vector_take_o)
    else $error("pending request not taken once");
  a_return_restores: assert property (return_from_interrupt_instr_i && !take_nxt |=> gie_r && restore_o)
    else $error("return did not restore and enable");
  a_sync_latency: assert property (tmr0_evt_i && gie_r && tmr0_en_r && state_r == IEC_ST_RUN && !sleep_i
                                   |-> ##[1:5] vector_take_o)
    else $error("synchronous request not taken in time");
  a_phase_one_sample: assert property (vector_take_o |-> $past(phase_r) == IEC_PH_ONE)
    else $error("vector not decided in phase one");
  a_wake_step_first: assert property (wake_o |-> !vector_take_o [*4])
    else $error("vector before instruction after sleep");
  a_edge_sets_flag: assert property (ext_edge |=> core_flags[0])
    else $error("pin edge did not set flag");
  a_status_saved_masked: assert property (vector_take_o |-> sh_status_o[IEC_BIT_TIMEOUT] == 1'b0 &&
                                          sh_status_o[IEC_BIT_POWERDOWN] == 1'b0)
    else $error("timeout or powerdown saved");

  c_vector_taken: cover property (vector_take_o);
  c_return_done:  cover property (restore_o ##[1:20] vector_take_o);
  c_wake_vector:  cover property (wake_o ##[4:12] vector_take_o);
  c_bus_read:     cover property (avs_read_i && !avs_waitrequest_o);
endmodule

// ===== dv/iec_core_model.sv
`timescale 1ns/100ps
module iec_core_model (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic [1:0]  phase_i,
  input  wire logic        take_i,
  input  wire logic        restore_i,
  input  wire logic [15:0] vec_i,
  input  wire logic [15:0] push_i,
  output logic      [15:0] pc_o
);
  logic [15:0] ret_r;
  // One instruction per four phases; a one-deep stack is enough since nesting never happens.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pc_o  <= 16'h0000;
      ret_r <= 16'h0000;
    end else if (take_i) begin
      pc_o  <= vec_i;
      ret_r <= push_i;
    end else if (restore_i) begin
      pc_o <= ret_r;
    end else if (phase_i == 2'h3) begin
      pc_o <= pc_o + 16'h0001;
    end
  end
endmodule

// ===== dv/testbench.sv
`timescale 1ns/100ps
module testbench;
  import iec_pkg::*;
  logic        clk_i = 1'b0, reset_i = 1'b1;
  logic [7:0]  avs_address_i, periph_evt1_i, periph_evt2_i, periph_evt3_i;
  logic        avs_read_i, avs_write_i, tmr0_evt_i, ext_pin_i, sleep_i, return_from_interrupt_instr_i;
  logic [3:0]  avs_byteenable_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, d, r;
  logic [5:0]  change_flags_i;
  logic [15:0] pc_i, pc_d, vector_pc_o, push_pc_o, sh_fsr0_o, sh_fsr1_o;
  logic [1:0]  phase_o;
  logic        avs_waitrequest_o, vector_take_o, restore_o, wake_o, global_irq_enable_o;
  logic [7:0]  sh_w_o, sh_status_o;
  logic [4:0]  sh_bsr_o;
  logic [6:0]  sh_pc_high_latch_o;
  logic [7:0]  amap [15] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C,
                             8'h40, 8'h44, 8'h48, 8'h4C, 8'h50, 8'h54, 8'h20};
  int          fails = 0, checks_done = 0, takes = 0, restores = 0, wakes = 0, seed, n;

  always #20 clk_i = ~clk_i;

  iec_core_model core (.clk_i(clk_i), .reset_i(reset_i), .phase_i(phase_o), .take_i(vector_take_o),
    .restore_i(restore_o), .vec_i(vector_pc_o), .push_i(push_pc_o), .pc_o(pc_i));

  iec_top uut (.clk_i(clk_i), .reset_i(reset_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_byteenable_i(avs_byteenable_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .tmr0_evt_i(tmr0_evt_i),
    .periph_evt1_i(periph_evt1_i), .periph_evt2_i(periph_evt2_i), .periph_evt3_i(periph_evt3_i),
    .change_flags_i(change_flags_i), .ext_pin_i(ext_pin_i), .sleep_i(sleep_i), .return_from_interrupt_instr_i(return_from_interrupt_instr_i),
    .pc_i(pc_i), .ctx_w_i(pc_i[7:0] ^ 8'h5A), .ctx_status_i({pc_i[3:0], pc_i[7:4]} | 8'h18),
    .ctx_bsr_i(pc_i[4:0]), .ctx_fsr0_i(~pc_i), .ctx_fsr1_i(pc_i ^ 16'h1234), .ctx_pc_high_latch_i(pc_i[6:0]),
    .phase_o(phase_o), .vector_take_o(vector_take_o), .vector_pc_o(vector_pc_o), .push_pc_o(push_pc_o),
    .restore_o(restore_o), .wake_o(wake_o), .global_irq_enable_o(global_irq_enable_o),
    .sh_w_o(sh_w_o), .sh_status_o(sh_status_o), .sh_bsr_o(sh_bsr_o), .sh_fsr0_o(sh_fsr0_o),
    .sh_fsr1_o(sh_fsr1_o), .sh_pc_high_latch_o(sh_pc_high_latch_o));

  task close_out;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [7:0] exp_status(input logic [15:0] p);
    return ({p[3:0], p[7:4]} | 8'h18) & IEC_STATUS_SAVE;
  endfunction

  // Holds the request until waitrequest is sampled low at a rising edge, takes data there, then releases.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge clk_i);
    avs_address_i   <= a;
    avs_writedata_i <= wd;
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    do begin
      @(posedge clk_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 10);
    if (k >= 10) begin
      fails++;
      close_out();
    end
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] wd);
    bus(1'b1, a, wd, d);
  endtask

  task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000, d);
    chk(nm, d, e);
  endtask

  task idle(input int k);
    repeat (k) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic wait_inc(ref int c, input int lim, output int m);
    int t;
    t = c;
    m = 0;
    while (c == t && m < lim) begin
      @(negedge clk_i);
      m++;
    end
    if (c == t) begin
      fails++;
      close_out();
    end
  endtask

  // Every entry is checked where it happens, so takes during bus cycles are not missed.
  always @(posedge clk_i) begin
    pc_d <= pc_i;
    if (!reset_i && vector_take_o === 1'b1) begin
      takes++;
      chk("vector_pc", vector_pc_o, IEC_VECTOR_ADDR);
      chk("push_pc", push_pc_o, pc_d);
      chk("gie_at_take", global_irq_enable_o, 1'b0);
      chk("take_phase", phase_o, 2'h1);
      chk("sh_w", sh_w_o, pc_d[7:0] ^ 8'h5A);
      chk("sh_status", sh_status_o, exp_status(pc_d));
      chk("sh_bsr", sh_bsr_o, pc_d[4:0]);
      chk("sh_fsr0", sh_fsr0_o, {16'h0000, ~pc_d});
      chk("sh_fsr1", sh_fsr1_o, pc_d ^ 16'h1234);
      chk("sh_pc_high_latch", sh_pc_high_latch_o, pc_d[6:0]);
    end
    if (!reset_i && restore_o === 1'b1) restores++;
    if (!reset_i && wake_o === 1'b1) wakes++;
  end

  initial begin
    #3000000;
    fails++;
    close_out();
  end

  initial begin
    seed = 14;
    {avs_address_i, avs_read_i, avs_write_i, avs_writedata_i, tmr0_evt_i, ext_pin_i} = '0;
    {periph_evt1_i, periph_evt2_i, periph_evt3_i, change_flags_i, sleep_i, return_from_interrupt_instr_i} = '0;
    avs_byteenable_i = 4'hF;
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    foreach (amap[i]) rd_chk("reset_value", amap[i], 32'h00000000);
    chk("gie_reset", global_irq_enable_o, 1'b0);
    $display("test reset done");
    r = $random(seed) | 32'h1;
    @(posedge clk_i);
    {periph_evt3_i, periph_evt2_i, periph_evt1_i} <= r[23:0];
    tmr0_evt_i <= 1'b1;
    @(posedge clk_i);
    {periph_evt3_i, periph_evt2_i, periph_evt1_i, tmr0_evt_i} <= '0;
    rd_chk("req1", IEC_OFS_PREQUEST1, {24'h0, r[7:0] & IEC_PE1_MASK});
    rd_chk("req2", IEC_OFS_PREQUEST2, {24'h0, r[15:8] & IEC_PE2_MASK});
    rd_chk("req3", IEC_OFS_PREQUEST3, {24'h0, r[23:16] & IEC_PE3_MASK});
    rd_chk("ctrl_flag", IEC_OFS_CONTROL, 32'h4);
    wr(IEC_OFS_PENABLE1, 32'hF3);
    wr(IEC_OFS_CONTROL, 32'h80);
    idle(16);
    chk("no_take_group_off", takes, 0);
    wr(IEC_OFS_CONTROL, 32'hC0);
    idle(16);
    chk("take_group_on", takes, 1);
    $display("test group gating done");
    @(posedge clk_i);
    return_from_interrupt_instr_i <= 1'b1;
    @(posedge clk_i);
    return_from_interrupt_instr_i <= 1'b0;
    idle(12);
    chk("retake_pending", takes, 2);
    r = $random(seed);
    wr(IEC_OFS_PREQUEST1, 32'h0);
    wr(IEC_OFS_SH_W, {24'h0, r[7:0]});
    rd_chk("sh_w_read", IEC_OFS_SH_W, {24'h0, r[7:0]});
    @(posedge clk_i);
    return_from_interrupt_instr_i <= 1'b1;
    @(posedge clk_i);
    return_from_interrupt_instr_i <= 1'b0;
    idle(12);
    chk("restores", restores, 2);
    chk("gie_after_return", global_irq_enable_o, 1'b1);
    chk("no_retake", takes, 2);
    chk("sh_w_kept", sh_w_o, r[7:0]);
    $display("test return done");
    wr(IEC_OFS_CONTROL, 32'hA0);
    @(posedge clk_i);
    tmr0_evt_i <= 1'b1;
    @(posedge clk_i);
    tmr0_evt_i <= 1'b0;
    wait_inc(takes, 20, n);
    chk("sync_latency", n <= 6, 1'b1);
    $display("test latency done");
    // The pin is first parked at the level before the selected edge, so every pass sees a real edge.
    for (int e = 1; e >= 0; e--) begin
      wr(IEC_OFS_OPTION, e);
      @(posedge clk_i);
      ext_pin_i <= !e[0];
      idle(6);
      wr(IEC_OFS_CONTROL, 32'h0);
      @(posedge clk_i);
      ext_pin_i <= e[0];
      idle(6);
      rd_chk("pin_selected", IEC_OFS_CONTROL, 32'h2);
      wr(IEC_OFS_CONTROL, 32'h0);
      @(posedge clk_i);
      ext_pin_i <= !e[0];
      idle(6);
      rd_chk("pin_other", IEC_OFS_CONTROL, 32'h0);
    end
    wr(IEC_OFS_CONTROL, 32'h90);
    @(posedge clk_i);
    ext_pin_i <= 1'b0;
    wait_inc(takes, 20, n);
    chk("async_latency", n <= 9, 1'b1);
    $display("test pin done");
    wr(IEC_OFS_CONTROL, 32'h0);
    @(posedge clk_i);
    change_flags_i <= 6'h04;
    idle(2);
    wr(IEC_OFS_CONTROL, 32'h0);
    rd_chk("summary_ro", IEC_OFS_CONTROL, 32'h1);
    @(posedge clk_i);
    change_flags_i <= 6'h00;
    idle(2);
    rd_chk("summary_clear", IEC_OFS_CONTROL, 32'h0);
    $display("test change summary done");
    for (int g = 0; g < 2; g++) begin
      wr(IEC_OFS_CONTROL, g ? 32'hA0 : 32'h20);
      @(posedge clk_i);
      sleep_i <= 1'b1;
      @(posedge clk_i);
      sleep_i <= 1'b0;
      tmr0_evt_i <= 1'b1;
      @(posedge clk_i);
      tmr0_evt_i <= 1'b0;
      wait_inc(wakes, 20, n);
      if (g == 0) begin
        idle(20);
        chk("wake_no_vector", takes, 4);
      end else begin
        wait_inc(takes, 20, n);
        chk("wake_delay", n >= 4, 1'b1);
      end
    end
    $display("test sleep done");
    close_out();
  end
endmodule
